// ==== hdl/bridge_status_config_sleep.sv ====
// Function
// - status byte after bus commands: bit0 checksum, bit1 address nack, bit3 start; rest zero
// - error pin active whenever any status bit is set
// - error pin cleared by a valid bus reset
// - checksum failure sets bit0, blocks transfer, write status reads FFh
// - address nack sets bit1, write status reads FFh
// - write status 00h if all acked, else index of first nacked byte
// - command D2h is followed by one byte; its low two bits load configuration, upper bits zero
// - rate field 00 100k, 01 400k, 10 900k; resets to 01
// - command E1h returns configuration in next read byte
// - command 1Eh enters sleep, same as sleep pin
// - active-low sleep pin enters sleep regardless of bus
// - asleep: all bus activity ignored, resets included
// - asleep: rising edge of wake pin leaves sleep once the sleep pin is high
// - zero length or count asserts error pin, waits for bus reset
// - checksum x16+x15+x2+1, received inverted, compared with computed
`timescale 1ns/10ps
`default_nettype none

module bridge_status_config_sleep
   import bridge_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       srst_i,
   // decoded bus link
   input  wire logic                       bus_reset_i,
   input  wire logic                       sel_i,
   input  wire logic                       rx_valid_i,
   input  wire logic [7:0]                 rx_data_i,
   input  wire logic                       rd_req_i,
   input  wire logic                       rd_sel_i,
   output logic                            tx_valid_o,
   output logic [7:0]                      tx_data_o,
   // packet checksum
   input  wire logic                       crc_clear_i,
   input  wire logic                       pkt_valid_i,
   input  wire logic [7:0]                 pkt_data_i,
   input  wire logic                       crc_chk_i,
   input  wire logic [15:0]                crc_rx_i,
   input  wire logic                       len_zero_i,
   // transfer engine
   output logic                            i2c_go_o,
   input  wire logic                       xact_done_i,
   input  wire bridge_ctrl_pkg::xact_result_s xact_res_i,
   output logic [1:0]                      i2c_rate_select_o,
   // pins
   input  wire logic                       sleep_req_n_i,
   input  wire logic                       wake_i,
   output logic                            asleep_o,
   output logic                            error_flag_pin_o
);
   import bridge_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // checksum step, lsb first

   function automatic logic [15:0] packet_checksum_error_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ b[i]) begin
            r = (r >> 1) ^ CRC_POLY_REFL;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic sleep_n_s1_q, sleep_n_s2_q;
   logic wake_s1_q, wake_s2_q, wake_s3_q;
   logic wake_rise;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sleep_n_s1_q <= SLEEP_N_RESET;
         sleep_n_s2_q <= SLEEP_N_RESET;
         wake_s1_q    <= WAKE_RESET;
         wake_s2_q    <= WAKE_RESET;
         wake_s3_q    <= WAKE_RESET;
      end else begin
         sleep_n_s1_q <= sleep_req_n_i;
         sleep_n_s2_q <= sleep_n_s1_q;
         wake_s1_q    <= wake_i;
         wake_s2_q    <= wake_s1_q;
         wake_s3_q    <= wake_s2_q;
      end
   end

   assign wake_rise = wake_s2_q & ~wake_s3_q;

   ////////////////////////////////////////////////////////////////////////////////
   // command sequencer and sleep

   ctrl_state_e state_q, state_d;
   logic        asleep_q, asleep_d;
   logic [7:0]  cfg_q, cfg_d;
   logic        awake;

   assign awake = ~asleep_q;

   always_comb begin
      state_d  = state_q;
      asleep_d = asleep_q;
      cfg_d    = cfg_q;
      if (asleep_q) begin
         if (wake_rise && sleep_n_s2_q) begin
            asleep_d = 1'b0;
            state_d  = ST_IDLE;
         end
      end else if (!sleep_n_s2_q) begin
         asleep_d = 1'b1;
         state_d  = ST_IDLE;
      end else if (bus_reset_i) begin
         state_d = ST_IDLE;
      end else if (len_zero_i) begin
         state_d = ST_HALT;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (sel_i) begin
                  state_d = ST_CMD;
               end
            end
            ST_CMD: begin
               if (rx_valid_i) begin
                  case (rx_data_i)
                     CMD_WRITE_CFG: state_d = ST_CFG_WR;
                     CMD_READ_CFG:  state_d = ST_CFG_RD;
                     CMD_SLEEP: begin
                        asleep_d = 1'b1;
                        state_d  = ST_IDLE;
                     end
                     default:       state_d = ST_IDLE;
                  endcase
               end
            end
            ST_CFG_WR: begin
               if (rx_valid_i) begin
                  cfg_d   = {6'h00, rx_data_i[CFG_RATE_W-1:0]};
                  state_d = ST_IDLE;
               end
            end
            ST_CFG_RD: begin
               if (rd_req_i) begin
                  state_d = ST_IDLE;
               end
            end
            ST_HALT: state_d = ST_HALT;
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q  <= ST_IDLE;
         asleep_q <= 1'b0;
         cfg_q    <= CFG_RESET;
      end else begin
         state_q  <= state_d;
         asleep_q <= asleep_d;
         cfg_q    <= cfg_d;
      end
   end

   assign asleep_o          = asleep_q;
   assign i2c_rate_select_o = cfg_q[CFG_RATE_W-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // checksum, status and write status

   logic [7:0]  stat_q, stat_d;
   logic [7:0]  wstat_q, wstat_d;
   logic [15:0] crc_q, crc_d;
   logic        len_err_q, len_err_d;
   logic        go_q, go_d;
   logic        crc_bad;

   assign crc_bad = (~crc_rx_i != crc_q);

   always_comb begin
      stat_d    = stat_q;
      wstat_d   = wstat_q;
      crc_d     = crc_q;
      len_err_d = len_err_q;
      go_d      = 1'b0;
      // clear first so that a same-cycle event wins
      if (awake && bus_reset_i) begin
         stat_d    = STAT_RESET;
         len_err_d = 1'b0;
      end
      if (awake && crc_clear_i) begin
         crc_d = CRC_INIT;
      end else if (awake && pkt_valid_i) begin
         crc_d = packet_checksum_error_byte(crc_q, pkt_data_i);
      end
      if (awake && crc_chk_i) begin
         stat_d = STAT_RESET;
         if (crc_bad) begin
            stat_d[STAT_BIT_CRC] = 1'b1;
            wstat_d              = WSTAT_INVALID;
         end else begin
            go_d = 1'b1;
         end
      end
      if (xact_done_i) begin
         stat_d[STAT_BIT_ADDR]  = xact_res_i.addr_nack;
         stat_d[STAT_BIT_START] = xact_res_i.bad_start;
         wstat_d = xact_res_i.addr_nack ? WSTAT_INVALID : xact_res_i.nack_index;
      end
      if (awake && len_zero_i) begin
         len_err_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         stat_q    <= STAT_RESET;
         wstat_q   <= WSTAT_ALL_ACK;
         crc_q     <= CRC_INIT;
         len_err_q <= 1'b0;
         go_q      <= 1'b0;
      end else begin
         stat_q    <= stat_d;
         wstat_q   <= wstat_d;
         crc_q     <= crc_d;
         len_err_q <= len_err_d;
         go_q      <= go_d;
      end
   end

   assign i2c_go_o         = go_q;
   assign error_flag_pin_o = (|stat_q) | len_err_q;

   ////////////////////////////////////////////////////////////////////////////////
   // read byte path

   logic       tx_valid_q, tx_valid_d;
   logic [7:0] tx_data_q, tx_data_d;

   always_comb begin
      tx_valid_d = awake & rd_req_i;
      tx_data_d  = tx_data_q;
      if (tx_valid_d) begin
         if (state_q == ST_CFG_RD) begin
            tx_data_d = cfg_q;
         end else begin
            tx_data_d = rd_sel_i ? wstat_q : stat_q;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_valid_q <= 1'b0;
         tx_data_q  <= 8'h00;
      end else begin
         tx_valid_q <= tx_valid_d;
         tx_data_q  <= tx_data_d;
      end
   end

   assign tx_valid_o = tx_valid_q;
   assign tx_data_o  = tx_data_q;

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_cfg_cmd;
      awake && sleep_n_s2_q && !bus_reset_i && !len_zero_i && state_q == ST_CMD
         && rx_valid_i && rx_data_i == CMD_WRITE_CFG;
   endsequence

   sequence s_cfg_byte;
      awake && sleep_n_s2_q && !bus_reset_i && !len_zero_i && state_q == ST_CFG_WR
         && rx_valid_i;
   endsequence

   property p_stat_zero_bits;
      @(posedge clk_i) disable iff (srst_i)
      stat_q[7:4] == 4'h0 && stat_q[2] == 1'b0;
   endproperty
   a_stat_zero_bits: assert property (p_stat_zero_bits) else $error("status reserved bit set");

   property p_err_on_nack;
      @(posedge clk_i) disable iff (srst_i)
      xact_done_i && xact_res_i.addr_nack |=> error_flag_pin_o && stat_q[STAT_BIT_ADDR];
   endproperty
   a_err_on_nack: assert property (p_err_on_nack) else $error("nack not flagged");

   property p_reset_clears;
      @(posedge clk_i) disable iff (srst_i)
      awake && bus_reset_i && !xact_done_i && !crc_chk_i && !len_zero_i |=> !error_flag_pin_o;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("error pin not cleared");

   property p_crc_fail;
      @(posedge clk_i) disable iff (srst_i)
      awake && crc_chk_i && crc_bad && !xact_done_i
         |=> stat_q[STAT_BIT_CRC] && wstat_q == WSTAT_INVALID && !i2c_go_o;
   endproperty
   a_crc_fail: assert property (p_crc_fail) else $error("checksum failure mishandled");

   property p_addr_wstat;
      @(posedge clk_i) disable iff (srst_i)
      xact_done_i && xact_res_i.addr_nack |=> wstat_q == WSTAT_INVALID;
   endproperty
   a_addr_wstat: assert property (p_addr_wstat) else $error("write status not FFh");

   property p_wstat_index;
      @(posedge clk_i) disable iff (srst_i)
      xact_done_i && !xact_res_i.addr_nack |=> wstat_q == $past(xact_res_i.nack_index);
   endproperty
   a_wstat_index: assert property (p_wstat_index) else $error("write status wrong");

   property p_cfg_write;
      logic [7:0] v;
      @(posedge clk_i) disable iff (srst_i)
      s_cfg_cmd ##[1:4] (s_cfg_byte, v = rx_data_i) |=> cfg_q == {6'h00, v[1:0]};
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("configuration not loaded");

   property p_cfg_upper_zero;
      @(posedge clk_i) disable iff (srst_i)
      cfg_q[7:2] == 6'h00 && i2c_rate_select_o == cfg_q[1:0];
   endproperty
   a_cfg_upper_zero: assert property (p_cfg_upper_zero) else $error("config high bits set");

   property p_rate_reset;
      @(posedge clk_i) srst_i |=> i2c_rate_select_o == RATE_400K;
   endproperty
   a_rate_reset: assert property (p_rate_reset) else $error("rate reset value wrong");

   property p_cfg_read;
      @(posedge clk_i) disable iff (srst_i)
      awake && rd_req_i && state_q == ST_CFG_RD |=> tx_valid_o && tx_data_o == $past(cfg_q);
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");

   property p_sleep_cmd;
      @(posedge clk_i) disable iff (srst_i)
      awake && !bus_reset_i && !len_zero_i && state_q == ST_CMD && rx_valid_i
         && rx_data_i == CMD_SLEEP |=> asleep_o;
   endproperty
   a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep command ignored");

   property p_sleep_pin;
      @(posedge clk_i) disable iff (srst_i)
      $fell(sleep_req_n_i) ##1 !sleep_req_n_i |=> ##1 asleep_o;
   endproperty
   a_sleep_pin: assert property (p_sleep_pin) else $error("sleep pin ignored");

   property p_asleep_ignores;
      @(posedge clk_i) disable iff (srst_i)
      asleep_o && !wake_rise |=> asleep_o && $stable(stat_q) && !tx_valid_o && $stable(cfg_q);
   endproperty
   a_asleep_ignores: assert property (p_asleep_ignores) else $error("bus seen while asleep");

   property p_wake;
      @(posedge clk_i) disable iff (srst_i)
      asleep_o && wake_rise && sleep_n_s2_q |=> !asleep_o && state_q == ST_IDLE;
   endproperty
   a_wake: assert property (p_wake) else $error("wake edge missed");

   property p_len_zero;
      @(posedge clk_i) disable iff (srst_i)
      awake && sleep_n_s2_q && len_zero_i && !bus_reset_i
         |=> error_flag_pin_o && state_q == ST_HALT;
   endproperty
   a_len_zero: assert property (p_len_zero) else $error("zero length not flagged");

   property p_crc_pass;
      @(posedge clk_i) disable iff (srst_i)
      awake && crc_chk_i && !crc_bad && !xact_done_i |=> i2c_go_o && !stat_q[STAT_BIT_CRC];
   endproperty
   a_crc_pass: assert property (p_crc_pass) else $error("good checksum rejected");

endmodule

`default_nettype wire

// ==== hdl/bridge_ctrl_pkg.sv ====
package bridge_ctrl_pkg;

   // device command codes
   localparam logic [7:0]  CMD_WRITE_CFG  = 8'hd2;
   localparam logic [7:0]  CMD_READ_CFG   = 8'he1;
   localparam logic [7:0]  CMD_SLEEP      = 8'h1e;

   // transaction status byte layout
   localparam int          STAT_BIT_CRC   = 0;
   localparam int          STAT_BIT_ADDR  = 1;
   localparam int          STAT_BIT_START = 3;
   localparam logic [7:0]  STAT_RESET     = 8'h00;

   // write status values
   localparam logic [7:0]  WSTAT_INVALID  = 8'hff;
   localparam logic [7:0]  WSTAT_ALL_ACK  = 8'h00;

   // configuration register
   localparam int          CFG_RATE_W     = 2;
   localparam logic [7:0]  CFG_RESET      = 8'h01;
   localparam logic [1:0]  RATE_100K      = 2'h0;
   localparam logic [1:0]  RATE_400K      = 2'h1;
   localparam logic [1:0]  RATE_900K      = 2'h2;

   // packet checksum, reflected form of x16+x15+x2+1
   localparam logic [15:0] CRC_POLY_REFL  = 16'ha001;
   localparam logic [15:0] CRC_INIT       = 16'h0000;

   // pin synchroniser reset levels
   localparam logic        SLEEP_N_RESET  = 1'b1;
   localparam logic        WAKE_RESET     = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_CMD    = 3'b001,
      ST_CFG_WR = 3'b010,
      ST_CFG_RD = 3'b011,
      ST_HALT   = 3'b100
   } ctrl_state_e;

   // outcome of one bus transaction from the transfer engine
   typedef struct packed {
      logic       addr_nack;
      logic       bad_start;
      logic [7:0] nack_index;
   } xact_result_s;

endpackage

// ==== dv/host.sv ====
`timescale 1ns/10ps
`default_nettype none
module host (
   // clock and answer
   input  wire logic        clk_i,
   input  wire logic        tx_valid_i,
   input  wire logic [7:0]  tx_data_i,
   // strobes 0 reset, 1 select, 2 byte, 3 read, 4 clear, 5 packet, 6 check, 7 zero
   output logic [7:0]       stb_o,
   output logic             rd_sel_o,
   output logic [7:0]       data_o,
   output logic [15:0]      crc_rx_o
);
   import bridge_ctrl_pkg::*;
   logic [7:0]  stb_q = 8'h00;
   logic [7:0]  data_q = 8'h00;
   logic [15:0] crc_q = 16'h0000;
   logic        rsel_q = 1'h0;
   assign stb_o = stb_q;
   assign rd_sel_o = rsel_q;
   assign data_o = data_q;
   assign crc_rx_o = crc_q;
   //////////////////////////////
   // a released byte shows its inverse, never the stale value
   task automatic pulse(input int idx, input logic [7:0] d);
      @(posedge clk_i);
      stb_q[idx] <= 1'h1;
      data_q <= d;
      @(posedge clk_i);
      stb_q[idx] <= 1'h0;
      data_q <= ~d;
   endtask
   task automatic command(input logic [7:0] c);
      pulse(0, 8'h00);
      pulse(1, 8'h00);
      pulse(2, c);
   endtask
   task automatic read_slot(input logic cfg, input logic rsel, output logic ok,
                            output logic [7:0] d);
      if (cfg) begin
         command(CMD_READ_CFG);
      end
      rsel_q <= rsel;
      pulse(3, 8'h00);
      rsel_q <= ~rsel;
      #1;
      ok = tx_valid_i;
      d = tx_data_i;
   endtask
   // checksum goes out inverted unless a fault is wanted
   task automatic packet(input logic bad);
      logic [7:0]  b [3] = '{8'h2d, 8'ha4, 8'h01};
      logic [15:0] c = 16'h0000;
      pulse(4, 8'h00);
      foreach (b[i]) begin
         pulse(5, b[i]);
         for (int k = 0; k < 8; k++) begin
            c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? 16'ha001 : 16'h0000);
         end
      end
      crc_q <= bad ? c : ~c;
      pulse(6, 8'h00);
      crc_q <= ~crc_q;
   endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bridge_ctrl_pkg::*;
   logic         clk_i = 1'h0;
   logic         srst_i = 1'h1;
   logic         xact_done_i = 1'h0;
   xact_result_s xact_res_i = '0;
   logic         sleep_req_n_i = 1'h1;
   logic         wake_i = 1'h0;
   logic         bus_reset_i, sel_i, rx_valid_i, rd_req_i, rd_sel_i, crc_clear_i;
   logic         pkt_valid_i, crc_chk_i, len_zero_i, tx_valid_o, i2c_go_o;
   logic         asleep_o, error_flag_pin_o;
   logic [1:0]   i2c_rate_select_o;
   logic [7:0]   stb, rx_data_i, pkt_data_i, tx_data_o;
   logic [15:0]  crc_rx_i;
   int           errors = 0;
   int           checks_done = 0;
   assign {len_zero_i, crc_chk_i, pkt_valid_i, crc_clear_i} = stb[7:4];
   assign {rd_req_i, rx_valid_i, sel_i, bus_reset_i} = stb[3:0];
   assign pkt_data_i = rx_data_i;
   always #2.5 clk_i = ~clk_i;
   bridge_status_config_sleep i_bridge_status_config_sleep (
      .clk_i, .srst_i, .bus_reset_i, .sel_i, .rx_valid_i, .rx_data_i, .rd_req_i,
      .rd_sel_i, .tx_valid_o, .tx_data_o, .crc_clear_i, .pkt_valid_i, .pkt_data_i,
      .crc_chk_i, .crc_rx_i, .len_zero_i, .i2c_go_o, .xact_done_i, .xact_res_i,
      .i2c_rate_select_o, .sleep_req_n_i, .wake_i, .asleep_o, .error_flag_pin_o
   );
   host i_host (
      .clk_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .stb_o(stb),
      .rd_sel_o(rd_sel_i), .data_o(rx_data_i), .crc_rx_o(crc_rx_i)
   );
   //////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic expect_read(input string what, input logic cfg, input logic rsel,
                              input logic [7:0] exp);
      logic       ok;
      logic [7:0] d;
      i_host.read_slot(cfg, rsel, ok, d);
      check({what, " valid"}, 8'h01, 8'(ok));
      check(what, exp, d);
   endtask
   task automatic wake_up;
      @(posedge clk_i);
      wake_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      #1;
      check("asleep before wake", 8'h01, 8'(asleep_o));
      @(posedge clk_i);
      wake_i <= 1'h0;
      #1;
      check("asleep after wake", 8'h00, 8'(asleep_o));
   endtask
   task automatic t_cfg;
      logic [7:0] v [5] = '{8'h01, 8'hfc, 8'hfe, 8'h02, 8'h01};
      foreach (v[i]) begin
         if (i > 0) begin
            i_host.command(CMD_WRITE_CFG);
            i_host.pulse(2, v[i]);
         end
         #1;
         check("rate", {6'h00, v[i][1:0]}, 8'(i2c_rate_select_o));
         expect_read("cfg", 1'h1, 1'h0, {6'h00, v[i][1:0]});
      end
   endtask
   task automatic t_crc;
      i_host.packet(1'h0);
      #1;
      check("go", 8'h01, 8'(i2c_go_o));
      expect_read("status", 1'h0, 1'h0, STAT_RESET);
      i_host.packet(1'h1);
      #1;
      check("go", 8'h00, 8'(i2c_go_o));
      check("err pin", 8'h01, 8'(error_flag_pin_o));
      expect_read("status", 1'h0, 1'h0, 8'h01);
      expect_read("wstat", 1'h0, 1'h1, 8'hff);
      i_host.pulse(0, 8'h00);
      #1;
      check("err pin", 8'h00, 8'(error_flag_pin_o));
   endtask
   task automatic t_xact;
      xact_result_s r [4] = '{'{1'h1, 1'h0, 8'h05}, '{1'h0, 1'h1, 8'h00},
                              '{1'h0, 1'h0, 8'h03}, '{1'h0, 1'h0, 8'h00}};
      logic [7:0]   st [4] = '{8'h02, 8'h08, 8'h00, 8'h00};
      logic [7:0]   ws [4] = '{8'hff, 8'h00, 8'h03, 8'h00};
      foreach (r[i]) begin
         @(posedge clk_i);
         xact_done_i <= 1'h1;
         xact_res_i <= r[i];
         @(posedge clk_i);
         xact_done_i <= 1'h0;
         #1;
         expect_read("status", 1'h0, 1'h0, st[i]);
         expect_read("wstat", 1'h0, 1'h1, ws[i]);
      end
   endtask
   task automatic t_sleep;
      logic       ok;
      logic [7:0] d;
      i_host.command(CMD_SLEEP);
      #1;
      check("asleep", 8'h01, 8'(asleep_o));
      i_host.read_slot(1'h0, 1'h0, ok, d);
      check("read asleep", 8'h00, 8'(ok));
      wake_up();
      i_host.pulse(7, 8'h00);
      #1;
      check("err pin", 8'h01, 8'(error_flag_pin_o));
      @(posedge clk_i);
      sleep_req_n_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      #1;
      check("asleep", 8'h01, 8'(asleep_o));
      @(posedge clk_i);
      sleep_req_n_i <= 1'h1;
      i_host.command(CMD_WRITE_CFG);
      i_host.pulse(2, 8'h02);
      wake_up();
      check("err pin", 8'h01, 8'(error_flag_pin_o));
      expect_read("cfg", 1'h1, 1'h0, CFG_RESET);
      check("err pin", 8'h00, 8'(error_flag_pin_o));
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      srst_i <= 1'h0;
      @(posedge clk_i);
      #1;
      t_cfg();
      t_crc();
      t_xact();
      t_sleep();
      give_verdict();
   end
   initial begin
      #50000;
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
